/* File: src/dicc_pkg.sv */
// Package with register map, fields and timing for the discrete input conditioner
package dicc_pkg;
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          TICK_MS         = 1;
  localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int          DELAY_W         = 16;
  localparam int          TYPE_W          = 2;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_DELAY       = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STAT    = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_EN      = 8'h10;
  localparam logic [7:0]  OFS_IRQ_CLR     = 8'h14;
  localparam logic [7:0]  OFS_TYPE        = 8'h18;
  // Control fields
  localparam int          CTRL_SIM_MODE   = 0;
  localparam int          CTRL_SIM_VAL    = 1;
  localparam int          CTRL_SIM_BAD    = 2;
  localparam int          CTRL_INVERT     = 3;
  localparam int          CTRL_LF_EN      = 4;
  localparam int          CTRL_STRAT_LO   = 5;
  localparam int          CTRL_SUBST_VAL  = 7;
  localparam int          CTRL_TOOL_LO    = 8;
  localparam int          CTRL_W          = 16;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [31:0] DELAY_RESET     = 32'h0000_0000;
  localparam logic [3:0]  TOOL_REV_INVALID = 4'h7;
  // Status / interrupt fields
  localparam int          IRQ_FAULT_SET   = 0;
  localparam int          IRQ_FAULT_CLR   = 1;
  localparam int          IRQ_VALUE_CHG   = 2;
  localparam int          IRQ_W           = 3;
  // Channel type codes, read-only
  localparam logic [1:0]  TYPE_DISCRETE_IN  = 2'h0;
  localparam logic [1:0]  TYPE_DISCRETE_OUT = 2'h1;
  localparam logic [1:0]  TYPE_ANALOG_IN    = 2'h2;
  localparam logic [1:0]  TYPE_ANALOG_OUT   = 2'h3;

  typedef enum logic [1:0] {
    STRAT_CURRENT,
    STRAT_SUBST,
    STRAT_LAST,
    STRAT_RSVD
  } dicc_strat_e;
endpackage

/* File: src/dicc_tick.sv */
// One-millisecond tick divider
`timescale 1ns/10ps
module dicc_tick #(
  parameter int CYCLES = dicc_pkg::TICK_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);
  logic [$clog2(CYCLES)-1:0] cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == $bits(cnt_q)'(CYCLES - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

/* File: src/dicc_delay.sv */
// ON/OFF delay filter counted in millisecond ticks
`timescale 1ns/10ps
module dicc_delay #(
  parameter int W = dicc_pkg::DELAY_W
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         tick,
  input  wire logic         din,
  input  wire logic [W-1:0] on_ms,
  input  wire logic [W-1:0] off_ms,
  output logic              dout
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] lim;

  assign lim = dout ? off_ms : on_ms;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout  <= 1'b0;
      cnt_q <= '0;
    end else if (din == dout) begin
      cnt_q <= '0;
    end else if (lim == '0) begin
      dout  <= din; // RQ15
      cnt_q <= '0;
    end else if (tick) begin
      // Rising waits on_ms, falling waits off_ms
      if (cnt_q + 1'b1 >= lim) begin
        dout  <= din; // RQ11 RQ12
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

/* File: src/dicc_top.sv */
// Discrete input channel conditioner with AHB-Lite register slave
// Function
// (RQ1) Normal mode forwards conditioned live input
// (RQ2) Simulation mode forwards simulated value instead
// (RQ3) Simulated bit with valid/invalid status
// (RQ4) Current-value strategy forwards field level on fault
// (RQ5) Substitute strategy forwards fixed configured bit
// (RQ6) Last-valid strategy holds pre-fault value
// (RQ7) Substitute bit always flagged invalid
// (RQ8) Error substitute invalid when tool revision >=7
// (RQ9) Inversion complements the input bit
// (RQ10) Line fault detection reports and triggers strategy
// (RQ11) ON delay suppresses short high pulses
// (RQ12) OFF delay stretches high pulses
// (RQ13) Channel enable follows module enable
// (RQ14) Fixed read-only channel type indication
// (RQ15) Millisecond tick; zero delay passes directly
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module dicc_top #(
  parameter int TICK_CYCLES = dicc_pkg::TICK_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        field_in,
  input  wire logic        lead_break,
  input  wire logic        short_circuit,
  input  wire logic        module_enable,
  output logic             chan_active,
  output logic             proc_value,
  output logic             proc_invalid,
  output logic             proc_fault,
  output logic             irq
);
  logic [dicc_pkg::CTRL_W-1:0]  ctrl_q;
  logic [31:0]                  delay_q;
  logic [dicc_pkg::IRQ_W-1:0]   irq_stat_q;
  logic [dicc_pkg::IRQ_W-1:0]   irq_en_q;
  logic [dicc_pkg::IRQ_W-1:0]   irq_clr;
  logic [dicc_pkg::IRQ_W-1:0]   irq_evt;
  logic                         wr_pend_q;
  logic [7:0]                   wr_addr_q;
  logic                         field_s1_q;
  logic                         field_s2_q;
  logic                         brk_s1_q;
  logic                         brk_s2_q;
  logic                         sc_s1_q;
  logic                         sc_s2_q;
  logic                         men_s1_q;
  logic                         men_s2_q;
  logic                         tick;
  logic                         cond;
  logic                         fault;
  logic                         fault_q;
  logic                         last_valid_q;
  logic                         value_d;
  logic                         invalid_d;
  logic                         prev_value_q;
  logic [3:0]                   tool_rev;
  dicc_pkg::dicc_strat_e        strat;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign strat     = dicc_pkg::dicc_strat_e'(ctrl_q[dicc_pkg::CTRL_STRAT_LO +: 2]);
  assign tool_rev  = ctrl_q[dicc_pkg::CTRL_TOOL_LO +: 4];

  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      field_s1_q <= 1'b0;
      field_s2_q <= 1'b0;
      brk_s1_q   <= 1'b0;
      brk_s2_q   <= 1'b0;
      sc_s1_q    <= 1'b0;
      sc_s2_q    <= 1'b0;
      men_s1_q   <= 1'b0;
      men_s2_q   <= 1'b0;
    end else begin
      field_s1_q <= field_in;
      field_s2_q <= field_s1_q;
      brk_s1_q   <= lead_break;
      brk_s2_q   <= brk_s1_q;
      sc_s1_q    <= short_circuit;
      sc_s2_q    <= sc_s1_q;
      men_s1_q   <= module_enable;
      men_s2_q   <= men_s1_q;
    end
  end

  dicc_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  dicc_delay #(
    .W (dicc_pkg::DELAY_W)
  ) u_delay (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .din     (field_s2_q ^ ctrl_q[dicc_pkg::CTRL_INVERT]), // RQ9
    .on_ms   (delay_q[15:0]),
    .off_ms  (delay_q[31:16]),
    .dout    (cond)
  );

  assign fault = ctrl_q[dicc_pkg::CTRL_LF_EN] & (brk_s2_q | sc_s2_q); // RQ10

  // Output value selection
  always_comb begin
    value_d   = cond; // RQ1
    invalid_d = 1'b0;
    if (ctrl_q[dicc_pkg::CTRL_SIM_MODE]) begin
      value_d   = ctrl_q[dicc_pkg::CTRL_SIM_VAL]; // RQ2
      invalid_d = ctrl_q[dicc_pkg::CTRL_SIM_BAD]; // RQ3
    end else if (fault) begin
      invalid_d = 1'b1; // RQ10
      case (strat)
        dicc_pkg::STRAT_SUBST: begin
          value_d   = ctrl_q[dicc_pkg::CTRL_SUBST_VAL]; // RQ5
          invalid_d = 1'b1; // RQ7 RQ8
        end
        dicc_pkg::STRAT_LAST: begin
          value_d = last_valid_q; // RQ6
          invalid_d = (tool_rev >= dicc_pkg::TOOL_REV_INVALID); // RQ8
        end
        dicc_pkg::STRAT_CURRENT: value_d = cond; // RQ4
        default: value_d = cond;
      endcase
    end
  end

  // Process image outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      proc_value   <= 1'b0;
      proc_invalid <= 1'b0;
      proc_fault   <= 1'b0;
      chan_active  <= 1'b0;
      fault_q      <= 1'b0;
      last_valid_q <= 1'b0;
      prev_value_q <= 1'b0;
    end else begin
      chan_active  <= men_s2_q; // RQ13
      fault_q      <= fault;
      prev_value_q <= proc_value;
      proc_fault   <= fault;
      proc_value   <= men_s2_q ? value_d : 1'b0;
      proc_invalid <= men_s2_q ? invalid_d : 1'b1;
      if (!fault && !ctrl_q[dicc_pkg::CTRL_SIM_MODE]) begin
        last_valid_q <= cond; // RQ6
      end
    end
  end

  assign irq_evt[dicc_pkg::IRQ_FAULT_SET] = fault & ~fault_q;
  assign irq_evt[dicc_pkg::IRQ_FAULT_CLR] = ~fault & fault_q;
  assign irq_evt[dicc_pkg::IRQ_VALUE_CHG] = proc_value ^ prev_value_q;

  // AHB-Lite write capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel & htrans[1] & hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  assign irq_clr = (wr_pend_q && wr_addr_q == dicc_pkg::OFS_IRQ_CLR) ?
                   hwdata[dicc_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= dicc_pkg::CTRL_RESET;
      delay_q  <= dicc_pkg::DELAY_RESET;
      irq_en_q <= '0;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        dicc_pkg::OFS_CTRL:   ctrl_q   <= hwdata[dicc_pkg::CTRL_W-1:0];
        dicc_pkg::OFS_DELAY:  delay_q  <= hwdata;
        dicc_pkg::OFS_IRQ_EN: irq_en_q <= hwdata[dicc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // Read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        dicc_pkg::OFS_CTRL:     hrdata <= {16'h0000, ctrl_q};
        dicc_pkg::OFS_DELAY:    hrdata <= delay_q;
        dicc_pkg::OFS_STATUS:   hrdata <= {28'h0000000, chan_active, proc_fault,
                                           proc_invalid, proc_value};
        dicc_pkg::OFS_IRQ_STAT: hrdata <= {29'h0, irq_stat_q};
        dicc_pkg::OFS_IRQ_EN:   hrdata <= {29'h0, irq_en_q};
        dicc_pkg::OFS_TYPE:     hrdata <= {30'h0, dicc_pkg::TYPE_DISCRETE_IN}; // RQ14
        default:                hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

/* File: dv/dicc_field_mdl.sv */
// Field contact model with line fault injection
`timescale 1ns/10ps
module dicc_field_mdl (
  input  wire logic       contact,
  input  wire logic [1:0] fault,
  output logic            field_in,
  output logic            lead_break,
  output logic            short_circuit
);
  // Open lead reads low, shorted lead reads high
  assign lead_break    = fault == 2'h1;
  assign short_circuit = fault == 2'h2;
  assign field_in      = lead_break ? 1'b0 : short_circuit ? 1'b1 : contact;
endmodule

/* File: dv/dicc_props.sv */
// Port checker for the conditioner
`timescale 1ns/10ps
module dicc_props #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        field_in,
  input wire logic        lead_break,
  input wire logic        short_circuit,
  input wire logic        module_enable,
  input wire logic        chan_active,
  input wire logic        proc_value,
  input wire logic        proc_invalid,
  input wire logic        proc_fault,
  input wire logic        irq
);
  logic        rd_q, wr_q;
  logic [7:0]  a_q;
  logic [15:0] ctrl_q;
  logic [31:0] dly_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      a_q  <= 8'h00;
    end else begin
      rd_q <= hsel && hready && htrans[1] && !hwrite;
      wr_q <= hsel && hready && htrans[1] && hwrite;
      a_q  <= haddr[7:0];
    end
  end
  // Shadow of control and delay words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 16'h0000;
      dly_q  <= 32'h0;
    end else if (wr_q && a_q == 8'h00) begin
      ctrl_q <= hwdata[15:0];
    end else if (wr_q && a_q == 8'h04) begin
      dly_q <= hwdata;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence calm_s(c);
    (c && module_enable && $stable(ctrl_q) && $stable(dly_q)) [*8];
  endsequence
  a_chan_on: assert property (module_enable [*4] |=> chan_active)
    else $error("channel inactive while enabled");
  a_chan_off: assert property (!module_enable [*4] |=> !chan_active)
    else $error("channel active while disabled");
  a_off_invalid: assert property (
    !module_enable [*8] |-> proc_invalid && !proc_value)
    else $error("disabled channel not invalid");
  a_sim_value: assert property (
    calm_s(ctrl_q[0]) |-> {proc_invalid, proc_value} == ctrl_q[2:1])
    else $error("simulated value mismatch");
  a_subst_out: assert property (
    calm_s(!ctrl_q[0] && ctrl_q[4] && ctrl_q[6:5] == 2'h1 && (lead_break || short_circuit))
      |-> proc_value == ctrl_q[7] && proc_invalid)
    else $error("substitute value mismatch");
  a_line_fault: assert property (
    calm_s(ctrl_q[4] && (lead_break || short_circuit)) |-> proc_fault)
    else $error("line fault not flagged");
  a_zero_pass: assert property (
    calm_s(!ctrl_q[0] && !ctrl_q[4] && dly_q == 32'h0 && $stable(field_in))
      |-> proc_value == (field_in ^ ctrl_q[3]) && !proc_invalid)
    else $error("live value not forwarded");
  a_type_read: assert property (rd_q && a_q >= 8'h18 |-> hrdata == 32'h0)
    else $error("type or unmapped read not zero");
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus response not okay or not ready");
endmodule
bind dicc_top dicc_props #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .field_in, .lead_break, .short_circuit, .module_enable, .chan_active, .proc_value,
  .proc_invalid, .proc_fault, .irq);

/* File: dv/testbench.sv */
// Testbench for the conditioner
`timescale 1ns/10ps
module testbench;
  logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, contact = 1'b0;
  logic        module_enable = 1'b1, hreadyout, hresp, field_in, lead_break;
  logic        short_circuit, chan_active, proc_value, proc_invalid, proc_fault, irq;
  logic [1:0]  htrans = 2'h0, fault = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  int          n_fail, compares, cfg, last;
  dicc_top #(.TICK_CYCLES(10)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .field_in,
    .lead_break, .short_circuit, .module_enable, .chan_active, .proc_value,
    .proc_invalid, .proc_fault, .irq);
  dicc_field_mdl fld_u (.contact, .fault, .field_in, .lead_break, .short_circuit);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // Expected {invalid, value} for a settled channel
  function automatic logic [1:0] model(input int f, input int flt);
    int v;
    v = f ^ (cfg >> 3 & 1);
    if (cfg & 1) return 2'(cfg >> 1);
    if (flt == 0 || !(cfg & 16)) return {1'b0, 1'(v)};
    if ((cfg >> 5 & 3) == 1) return {1'b1, 1'(cfg >> 7)};
    if ((cfg >> 5 & 3) == 2) return {1'((cfg >> 8 & 15) >= 7), 1'(last)};
    return {1'b1, 1'(v)};
  endfunction
  task automatic step(input int ctl, input int c, input int flt);
    cfg = ctl;
    wr(8'h00, 32'(ctl));
    contact <= c[0];
    fault   <= flt[1:0];
    repeat (12) @(negedge hclk);
    chk({30'h0, proc_invalid, proc_value}, {30'h0, model(flt == 1 ? 0 : flt ? 1 : c, flt)});
    chk({31'h0, proc_fault}, {31'h0, flt != 0 && (ctl & 16) != 0});
    if (flt == 0 && (ctl & 1) == 0) last = c ^ (ctl >> 3 & 1);
  endtask
  task automatic pulse(input int hi, input int look, input logic e);
    logic any, all;
    any = 1'b0;
    all = 1'b1;
    @(posedge hclk);
    contact <= 1'b1;
    repeat (hi) @(posedge hclk);
    contact <= 1'b0;
    repeat (look) begin
      @(negedge hclk);
      any |= proc_value;
      all &= proc_value;
    end
    chk({31'h0, e ? all : any}, {31'h0, e});
  endtask
  initial begin
    #400us;
    n_fail++;
    summarize();
  end
  initial begin
    void'($urandom(32'h95fd5182));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(8'h18, 32'hffff_ffff, 32'h0);
    wr(8'h18, 32'hffff_ffff);
    rdc(8'h18, 32'hffff_ffff, 32'h0);
    rdc(8'h1c, 32'hffff_ffff, 32'h0);
    for (int i = 0; i < 10; i++) step($urandom & 8, $urandom & 1, 0);
    for (int i = 0; i < 8; i++) step(1 | (i & 3) << 1 | (i & 4) << 2, $urandom & 1, i >> 2);
    for (int i = 0; i < 16; i++) begin
      step(16 | (i & 3) << 5 | (i & 4) << 5 | (i & 8 ? 7 : 6) << 8, ~i & 1, 0);
      step(cfg, ~i & 1, 1 + (i & 1));
    end
    step(16, 1, 0);
    wr(8'h14, 32'h7);
    wr(8'h10, 32'h1);
    chk_irq(1'b0);
    step(16, 1, 1);
    chk_irq(1'b1);
    rdc(8'h0c, 32'h1, 32'h1);
    wr(8'h10, 32'h0);
    chk_irq(1'b0);
    wr(8'h10, 32'h1);
    chk_irq(1'b1);
    wr(8'h14, 32'h1);
    chk_irq(1'b0);
    rdc(8'h0c, 32'h1, 32'h0);
    step(0, 0, 0);
    wr(8'h04, 32'h0003_0003);
    pulse(10, 60, 1'b0);
    pulse(80, 12, 1'b1);
    repeat (60) @(negedge hclk);
    chk({31'h0, proc_value}, 32'h0);
    @(posedge hclk);
    module_enable <= 1'b0;
    repeat (12) @(negedge hclk);
    chk({29'h0, chan_active, proc_invalid, proc_value}, 32'h2);
    summarize();
  end
endmodule
